// ===== clock_select.sv
// system clock select, prescaler control and clock monitor
// Overview of operation
// - every reset sets speed-up bit
// - software writes speed-up bit freely
// - speed-up acts only with option 011
// - divider select gives 1, 2, 4, 12
// - crystal bypasses divider with option 011, source bit clear
// - rc-on bit switches internal RC
// - source bit picks crystal or RC
// - rc-on and source need option 011
// - rc-on clear ignored while RC runs
// - monitor off while RC is source
// - failure falls back to watchdog RC
// - interrupt needs both enables set
// - clock return restores selection, clears flag
// - fail flag read-only, hardware owned
// - monitor idle when option is RC
// - divided clock drives the CPU
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_cfg.svh"
module clock_select
  import clock_select_pkg::*;
#(
  parameter int FAIL_LIMIT = `FAIL_TICKS  // watchdog ticks to fail
)
(
  input  wire logic                       clk_sys,          // 250 MHz clock
  input  wire logic                       rst_n,            // sync reset, low
  input  wire clock_select_pkg::apb_req_t apbReq,           // apb request
  output      clock_select_pkg::apb_rsp_t apbRsp,           // apb answer
  input  wire logic [2:0]                 oscillatorOption, // option straps
  input  wire logic                       oscTick,          // oscillator tick
  input  wire logic                       rcTick,           // internal rc tick
  input  wire logic                       wdtTick,          // watchdog rc tick
  input  wire logic                       globalIrqEnable,  // global enable
  input  wire logic                       monitorIrqEnable, // monitor enable
  output      logic                       xtalSpeedupOn,    // speed-up drive
  output      logic                       internalRcOn,     // rc enable drive
  output      logic                       srcIsRc,          // rc is prescaler
  output      logic                       cpuClockTick,     // cpu clock tick
  output      logic                       monitorIrq        // monitor irq
);
  import clock_select_pkg::*;

  // the tick counter is eight bits wide, so larger limits cannot be met
  if (FAIL_LIMIT < 1 || FAIL_LIMIT > 255)
  begin
    $error("fail limit out of range");
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic       speedup_reg;   // speed-up control
  logic       speedup_next;
  logic [1:0] divSel_reg;    // divider select
  logic [1:0] divSel_next;
  logic       internal_rc_on_reg;      // internal rc on
  logic       internal_rc_on_next;
  logic       srcSel_reg;    // source select
  logic       srcSel_next;
  logic [31:0] rdata_reg;    // read data
  logic [31:0] rdata_next;
  logic        err_reg;      // slave error
  logic        err_next;

  // monitor state
  mon_state_t monState_reg;  // monitor fsm
  mon_state_t monState_next;
  logic [7:0] wdtCnt_reg;    // ticks since last osc edge
  logic [7:0] wdtCnt_next;
  logic       failFlag;      // decoded fail flag

  // option decode helpers
  logic optXtal;             // crystal option active
  logic rcRunning;           // rc currently the source
  logic apbWrite;            // write completes this cycle
  logic apbRead;             // read setup phase this cycle
  logic hitReg;              // address decode

  assign optXtal   = (oscillatorOption == `OPT_XTAL32);
  // bits act only with option 011
  assign rcRunning = optXtal && internal_rc_on_reg && srcSel_reg;
  assign hitReg    = (apbReq.paddr == `CLKCTL_ADDR);
  // zero-wait slave: access phase always completes
  assign apbWrite  = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign apbRead   = apbReq.psel && !apbReq.penable && !apbReq.pwrite;

  // pack the register image for reads
  function automatic logic [7:0] pack_reg(input logic su,
                                          input logic [1:0] ds,
                                          input logic ff,
                                          input logic ro,
                                          input logic ss);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_SPEEDUP]   = su;
    v[`BIT_DIVSEL_HI] = ds[1];
    v[`BIT_DIVSEL_LO] = ds[0];
    v[`BIT_FAILFLAG]  = ff;
    v[`BIT_INTERNAL_RC_ON]      = ro;
    v[`BIT_SRCSEL]    = ss;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // register file next state
  // ---------------------------------------------------------------
  always_comb
  begin
    speedup_next = speedup_reg;
    divSel_next  = divSel_reg;
    internal_rc_on_next    = internal_rc_on_reg;
    srcSel_next  = srcSel_reg;
    rdata_next   = rdata_reg;
    err_next     = 1'b0;
    // read data sampled in setup, so it is a flop at access
    if (apbRead)
    begin
      if (hitReg)
        rdata_next = {24'h00_0000, pack_reg(speedup_reg, divSel_reg,
                      failFlag, internal_rc_on_reg, srcSel_reg)};
      else
        rdata_next = 32'h0000_0000;
    end
    if (apbReq.psel && !apbReq.penable)
      err_next = !hitReg;
    if (apbWrite && hitReg)
    begin
      speedup_next = apbReq.pwdata[`BIT_SPEEDUP];
      divSel_next  = apbReq.pwdata[`BIT_DIVSEL_HI:`BIT_DIVSEL_LO];
      srcSel_next  = apbReq.pwdata[`BIT_SRCSEL];
      // clearing rc-on refused while rc runs
      if (!(internal_rc_on_reg && srcSel_reg) || apbReq.pwdata[`BIT_INTERNAL_RC_ON])
        internal_rc_on_next = apbReq.pwdata[`BIT_INTERNAL_RC_ON];
      // fail flag bit of the write is dropped
    end
  end

  // register file flops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      speedup_reg <= `RST_SPEEDUP;
      divSel_reg  <= `RST_DIVSEL;
      // crystal drives the prescaler until software picks rc
      internal_rc_on_reg    <= `RST_INTERNAL_RC_ON;
      srcSel_reg  <= `RST_SRCSEL;
      rdata_reg   <= 32'h0000_0000;
      err_reg     <= 1'b0;
    end
    else
    begin
      speedup_reg <= speedup_next;
      divSel_reg  <= divSel_next;
      internal_rc_on_reg    <= internal_rc_on_next;
      srcSel_reg  <= srcSel_next;
      rdata_reg   <= rdata_next;
      err_reg     <= err_next;
    end
  end

  // zero-wait slave: every access phase is its last
  assign apbRsp.pready  = 1'b1;
  // error shows only in access, so setup never sees a stale one
  assign apbRsp.pslverr = err_reg & apbReq.penable;
  // read word captured at setup stands through access
  assign apbRsp.prdata  = rdata_reg;

  // ---------------------------------------------------------------
  // clock monitor
  // ---------------------------------------------------------------
  logic monEnable;  // monitor allowed to run
  // idle when option is internal rc
  assign monEnable = !rcRunning && (oscillatorOption != `OPT_INTRC);

  // monitor next state; watchdog rc paces the timeout because
  // it is the one clock that keeps running when the crystal dies
  always_comb
  begin
    monState_next = monState_reg;
    wdtCnt_next   = wdtCnt_reg;
    case (monState_reg)
      MON_IDLE:
      begin
        // hold the count clear while blocked
        wdtCnt_next = 8'h00;
        if (monEnable)
          monState_next = MON_OK;
      end
      MON_OK:
      begin
        if (!monEnable)
          monState_next = MON_IDLE;
        else if (oscTick)
          wdtCnt_next = 8'h00;
        else if (wdtTick)
        begin
          // no osc edge in limit ticks
          if (wdtCnt_reg == 8'(FAIL_LIMIT - 1))
            monState_next = MON_FAIL;
          else
            wdtCnt_next = wdtCnt_reg + 8'h01;
        end
      end
      MON_FAIL:
      begin
        wdtCnt_next = 8'h00;
        // limitation: one oscillator tick counts as recovery
        // oscillator back restores selection
        if (oscTick || !monEnable)
          monState_next = monEnable ? MON_OK : MON_IDLE;
      end
      default:
        monState_next = MON_IDLE;
    endcase
  end

  // monitor flops
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // monitor starts idle: no judgement before a full count
      monState_reg <= MON_IDLE;
      wdtCnt_reg   <= 8'h00;
    end
    else
    begin
      monState_reg <= monState_next;
      wdtCnt_reg   <= wdtCnt_next;
    end
  end

  // flag is set in fail state
  assign failFlag = (monState_reg == MON_FAIL);

  // ---------------------------------------------------------------
  // source select and prescaler
  // ---------------------------------------------------------------
  logic       srcTick;   // prescaler input tick
  logic [3:0] lastCnt;   // ratio minus one

  // prescaler source and ratio; failure fallback has the last word
  always_comb
  begin
    // failed oscillator falls back to watchdog rc
    if (failFlag)
      srcTick = wdtTick;
    else if (rcRunning)
      srcTick = rcTick;
    else
      srcTick = oscTick;
    if (optXtal && !srcSel_reg)
      lastCnt = `DIV1_LAST;
    else
    begin
      case (divSel_reg)
        2'b00:   lastCnt = `DIV1_LAST;
        2'b01:   lastCnt = `DIV2_LAST;
        2'b10:   lastCnt = `DIV4_LAST;
        2'b11:   lastCnt = `DIV12_LAST;
        default: lastCnt = `DIV1_LAST;
      endcase
    end
  end

  clock_divider #(.CNT_W(4)) divider
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .srcTick (srcTick),
    .lastCnt (lastCnt),
    .sysTick (cpuClockTick)
  );

  // ---------------------------------------------------------------
  // analog controls and interrupt
  // ---------------------------------------------------------------
  // speed-up only with crystal option
  assign xtalSpeedupOn = optXtal & speedup_reg;
  // rc on drive, gated by option
  assign internalRcOn  = optXtal & internal_rc_on_reg;
  // rc selection as seen by the core
  assign srcIsRc       = rcRunning;
  // level output: stands while the clock stays failed
  // both enables needed
  assign monitorIrq    = failFlag & globalIrqEnable & monitorIrqEnable;
endmodule
`default_nettype wire

// ===== clock_select_cfg.svh
// constants for the system clock select and monitor block
`ifndef CLOCK_SELECT_CFG_SVH
`define CLOCK_SELECT_CFG_SVH
// register byte address (printed offset is not a multiple of four: index)
`define CLKCTL_INDEX      8'hb2
`define CLKCTL_ADDR       12'h2c8
// field positions
`define BIT_SPEEDUP       7
`define BIT_DIVSEL_HI     6
`define BIT_DIVSEL_LO     5
`define BIT_FAILFLAG      4
`define BIT_INTERNAL_RC_ON          3
`define BIT_SRCSEL        2
// reset values
`define RST_SPEEDUP       1'b1
`define RST_DIVSEL        2'b11
`define RST_INTERNAL_RC_ON          1'b0
`define RST_SRCSEL        1'b0
// oscillator option code meaning 32.768 kHz crystal
`define OPT_XTAL32        3'b011
// oscillator option code meaning internal RC as oscillator clock
`define OPT_INTRC         3'b100
// divider terminal counts (ratio minus one)
`define DIV1_LAST         4'h0
`define DIV2_LAST         4'h1
`define DIV4_LAST         4'h3
`define DIV12_LAST        4'hb
// monitor failure threshold in watchdog RC ticks
`define FAIL_TICKS        4
`endif

// ===== clock_select_pkg.sv
// types shared by the clock select block
package clock_select_pkg;
  // apb request carrier
  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  // apb answer carrier
  typedef struct packed
  {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  // monitor states
  typedef enum logic [1:0]
  {
    MON_IDLE = 2'b00,
    MON_OK   = 2'b01,
    MON_FAIL = 2'b10
  } mon_state_t;
endpackage

// ===== clock_divider.sv
// divide-by-N enable generator for the system clock
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_cfg.svh"
module clock_divider
#(
  parameter int CNT_W = 4  // counter width
)
(
  input  wire logic             clk_sys,  // system clock
  input  wire logic             rst_n,    // sync reset, low
  input  wire logic             srcTick,  // prescaler input tick
  input  wire logic [CNT_W-1:0] lastCnt,  // ratio minus one
  output logic                  sysTick   // system clock tick
);
  // below four bits the divide-by-12 count cannot be held
  if (CNT_W < 4)
  begin
    $error("counter too narrow for divide by 12");
  end

  logic [CNT_W-1:0] cnt_reg;   // tick counter
  logic [CNT_W-1:0] cnt_next;  // next count
  logic             tick_reg;  // registered output
  logic             tick_next; // next output

  // count source ticks, pulse on terminal count
  always_comb
  begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (srcTick)
    begin
      if (cnt_reg >= lastCnt)
      begin
        cnt_next  = '0;
        tick_next = 1'b1;
      end
      else
        cnt_next = cnt_reg + 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign sysTick = tick_reg;
endmodule
`default_nettype wire

// ===== clock_select_sva.sv
// checker for the clock select block ports
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_cfg.svh"
module clock_select_sva
  import clock_select_pkg::*;
#(
  parameter int FAIL_LIMIT = 4  // watchdog ticks to fail
)
(
  input wire logic       clk_sys,          // clock
  input wire logic       rst_n,            // reset, low
  input wire apb_req_t   apbReq,           // apb request
  input wire apb_rsp_t   apbRsp,           // apb answer
  input wire logic [2:0] oscillatorOption, // option straps
  input wire logic       oscTick,          // crystal tick
  input wire logic       rcTick,           // rc tick
  input wire logic       wdtTick,          // watchdog tick
  input wire logic       globalIrqEnable,  // global enable
  input wire logic       monitorIrqEnable, // monitor enable
  input wire logic       xtalSpeedupOn,    // speed-up drive
  input wire logic       internalRcOn,     // rc enable
  input wire logic       srcIsRc,          // rc selected
  input wire logic       cpuClockTick,     // cpu tick
  input wire logic       monitorIrq        // interrupt
);
  logic anyTick;  // some source ticked
  assign anyTick = oscTick | rcTick | wdtTick;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  speed_reset_a : assert property (
    $rose(rst_n) |-> xtalSpeedupOn == (oscillatorOption == 3'b011))
    else $error("speed-up not set by reset");
  speed_gate_a : assert property (
    oscillatorOption != 3'b011 |-> !xtalSpeedupOn)
    else $error("speed-up acts without crystal option");
  rc_gate_a : assert property (
    oscillatorOption != 3'b011 |-> !internalRcOn && !srcIsRc)
    else $error("rc control acts without crystal option");
  src_rc_a : assert property (
    srcIsRc |-> internalRcOn)
    else $error("rc selected while rc off");
  rc_hold_a : assert property (
    srcIsRc ##1 (oscillatorOption == 3'b011) |-> internalRcOn)
    else $error("running rc was stopped");
  irq_enable_a : assert property (
    monitorIrq |-> globalIrqEnable && monitorIrqEnable)
    else $error("interrupt without both enables");
  tick_cause_a : assert property (
    cpuClockTick |-> $past(anyTick))
    else $error("cpu tick without source tick");
  intrc_quiet_a : assert property (
    oscillatorOption == 3'b100 ##1 oscillatorOption == 3'b100
    |-> !monitorIrq)
    else $error("monitor active with rc option");
  ready_now_a : assert property (
    apbReq.psel && apbReq.penable |-> apbRsp.pready)
    else $error("access phase not ready");
  bad_addr_a : assert property (
    apbReq.psel && apbReq.penable && apbReq.paddr != `CLKCTL_ADDR
    |-> apbRsp.pslverr)
    else $error("unmapped access without error");
endmodule
`default_nettype wire

// ===== clock_source_model.sv
// oscillator tick source feeding the clock select block
`timescale 1ns/1ns
`default_nettype none
module clock_source_model
(
  input wire logic clk_sys, // clock
  input wire logic oscRun,  // crystal oscillates
  output logic     oscTick, // crystal tick, every 3
  output logic     rcTick,  // rc tick, every 2
  output logic     wdtTick  // watchdog tick, every 5
);
  logic [4:0] phase = 5'h00;  // shared mod-30 phase
  // free running; 30 keeps all three periods exact
  always_ff @(posedge clk_sys)
    phase <= (phase == 5'd29) ? 5'd0 : phase + 5'd1;
  // stopped crystal gives no ticks at all
  assign oscTick = oscRun && (phase % 3 == 0);
  assign rcTick  = (phase % 2 == 0);
  assign wdtTick = (phase % 5 == 0);
endmodule
`default_nettype wire

// ===== tb_clock_select.sv
// self-checking bench for the clock select block
`timescale 1ns/1ns
`default_nettype none
`include "clock_select_cfg.svh"
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module tb_clock_select;
  import clock_select_pkg::*;
  localparam logic [11:0] REG = `CLKCTL_ADDR;  // control word
  logic        clk_sys, rst_n, oscRun;         // clock, reset, osc
  logic        globalIrqEnable, monitorIrqEnable;
  logic [2:0]  oscillatorOption;               // straps
  apb_req_t    apbReq;                         // bus request
  apb_rsp_t    apbRsp;                         // bus answer
  logic        oscTick, rcTick, wdtTick, xtalSpeedupOn;
  logic        internalRcOn, srcIsRc, cpuClockTick, monitorIrq;
  logic [31:0] rd;                             // last read data
  logic        err;                            // last error
  int          mismatches, n_checks;
  clock_select dut (.clk_sys, .rst_n, .apbReq, .apbRsp,
    .oscillatorOption, .oscTick, .rcTick, .wdtTick, .globalIrqEnable,
    .monitorIrqEnable, .xtalSpeedupOn, .internalRcOn, .srcIsRc,
    .cpuClockTick, .monitorIrq);
  clock_source_model osc (.clk_sys, .oscRun, .oscTick, .rcTick, .wdtTick);
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // one apb transfer; waits for pready, no fixed latency
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge clk_sys);
  endtask
  // cycles between two cpu ticks
  task automatic gap(input int n);
    int c;
    c = 0;
    while (cpuClockTick !== 1'b1 && c < 100)
    begin
      @(posedge clk_sys);
      c++;
    end
    c = 0;
    do
    begin
      @(posedge clk_sys);
      c++;
    end while (cpuClockTick !== 1'b1 && c < 100);
    `CHK(c, n)
  endtask
  task automatic t_reset;
    apb(1'b0, REG, 32'h0);
    `CHK(rd, 32'h0000_00e0)
  endtask
  task automatic t_divide;
    int r[4] = '{1, 2, 4, 12};
    apb(1'b1, REG, 32'h0000_0008);
    repeat (8) @(posedge clk_sys);
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, REG, 32'(d * 32 + 12));
      `CHK(srcIsRc, 1'b1)
      gap(2 * r[d]);
    end
  endtask
  task automatic t_rc_hold;
    apb(1'b1, REG, 32'h0000_0010);
    apb(1'b0, REG, 32'h0);
    `CHK(rd, 32'h0000_0008)
    `CHK(internalRcOn, 1'b1)
  endtask
  task automatic t_crystal;
    apb(1'b1, REG, 32'h0000_0060);
    `CHK({xtalSpeedupOn, internalRcOn}, 2'b00)
    gap(3);
    apb(1'b1, REG, 32'h0000_0080);
    `CHK(xtalSpeedupOn, 1'b1)
  endtask
  task automatic t_unmapped;
    apb(1'b1, 12'h000, 32'h0000_00ff);
    apb(1'b0, 12'h000, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b0, REG, 32'h0);
    `CHK(rd, 32'h0000_0080)
  endtask
  task automatic t_option;
    oscillatorOption <= 3'b000;
    repeat (2) @(posedge clk_sys);
    `CHK({xtalSpeedupOn, internalRcOn, srcIsRc}, 3'b000)
    oscillatorOption <= 3'b011;
    @(posedge clk_sys);
  endtask
  task automatic t_fail;
    int c;
    c = 0;
    oscRun <= 1'b0;
    while (monitorIrq !== 1'b1 && c < 100)
    begin
      @(posedge clk_sys);
      c++;
    end
    `CHK(monitorIrq, 1'b1)
    apb(1'b0, REG, 32'h0);
    `CHK(rd, 32'h0000_0090)
    gap(5);
    globalIrqEnable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(monitorIrq, 1'b0)
    oscRun <= 1'b1;
    repeat (10) @(posedge clk_sys);
    apb(1'b0, REG, 32'h0);
    `CHK(rd, 32'h0000_0080)
    gap(3);
    globalIrqEnable <= 1'b1;
  endtask
  task automatic t_intrc;
    oscillatorOption <= 3'b100;
    oscRun <= 1'b0;
    repeat (60) @(posedge clk_sys);
    `CHK(monitorIrq, 1'b0)
    apb(1'b0, REG, 32'h0);
    `CHK(rd[4], 1'b0)
  endtask
  // rc as source blocks the monitor; a late reset restores defaults
  task automatic t_rc_reset;
    oscillatorOption <= 3'b011;
    oscRun <= 1'b1;
    apb(1'b1, REG, 32'h0000_0008);
    repeat (8) @(posedge clk_sys);
    apb(1'b1, REG, 32'h0000_000c);
    oscRun <= 1'b0;
    repeat (60) @(posedge clk_sys);
    `CHK(monitorIrq, 1'b0)
    apb(1'b0, REG, 32'h0);
    `CHK(rd, 32'h0000_000c)
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    oscRun <= 1'b1;
    @(posedge clk_sys);
    `CHK(xtalSpeedupOn, 1'b1)
    apb(1'b0, REG, 32'h0);
    `CHK(rd, 32'h0000_00e0)
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    oscRun = 1'b1;
    oscillatorOption = 3'b011;
    globalIrqEnable = 1'b1;
    monitorIrqEnable = 1'b1;
    apbReq = '0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_divide();
    t_rc_hold();
    t_crystal();
    t_unmapped();
    t_option();
    t_fail();
    t_intrc();
    t_rc_reset();
    results();
  end
  // run needs about 400 cycles; far more is a hang
  initial
  begin
    #100000;
    mismatches++;
    results();
  end
endmodule
bind clock_select clock_select_sva #(.FAIL_LIMIT(FAIL_LIMIT)) chk (
  .clk_sys, .rst_n, .apbReq, .apbRsp, .oscillatorOption, .oscTick,
  .rcTick, .wdtTick, .globalIrqEnable, .monitorIrqEnable,
  .xtalSpeedupOn, .internalRcOn, .srcIsRc, .cpuClockTick, .monitorIrq);
`default_nettype wire
